// ---- rtl/acfg_top.sv ----
// Arming configuration and device status register bank, AXI4-Lite slave.
// Assumes fault inputs and the link sample clock arrive asynchronously;
// the arming comparator and filters outside consume the decoded outputs.
`timescale 1ns/1ps
`include "acfg_regs.svh"

// Notes on behaviour
// - Average mode: window fields give averaged sample counts per axis, polarity.
// - Average decode: 00, 01, 10, 11 give 2, 4, 8, 16 samples.
// - Count mode limit uses positive field only: 1, 3, 7, 15.
// - Thresholds writable before init-done lock, locked after it.
// - All four thresholds are covered by the writable register CRC.
// - Each threshold is an independent unsigned 8-bit value, one LSB each.
// - Zero threshold disables comparisons for that polarity only.
// - Both thresholds zero disables axis arming and its pin, any mode.
// - Condition flags read only; a read clears transient flags.
// - Flag bits 7 and 5 are unused and read as zero.
// - Bit 6 data fault set by CRC, fuse or internal faults, read clears.
// - Data fault re-asserts while CRC, fuse or internal fault persists.
// - Bit 4 init flag held until init completes; reads leave it.
// - Bit 3 set on serial output mismatch, read clears.
// - Bits 2 and 1 set on Y/X offset limit, read clears.
// - Bit 0 set during init after any reset, read clears.
// - Init-done lock cannot be cleared except by reset.
// - 3-bit CRC x^3+x+1 seed 111 checked only while locked.
module acfg_top #(
	parameter int INIT_CYCLES = `ACFG_INIT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic link_sample_clk,
	input wire logic offset_x_hit,
	input wire logic offset_y_hit,
	input wire logic miso_mismatch,
	input wire logic fuse_data_fault,
	input wire logic internal_fault,
	output logic [1:0] arm_mode,
	output logic [7:0] thresh_value_x_pos,
	output logic [7:0] thresh_value_y_pos,
	output logic [7:0] thresh_value_x_neg,
	output logic [7:0] thresh_value_y_neg,
	output logic [4:0] window_len_x_pos,
	output logic [4:0] window_len_x_neg,
	output logic [4:0] window_len_y_pos,
	output logic [4:0] window_len_y_neg,
	output logic [3:0] count_limit_x,
	output logic [3:0] count_limit_y,
	output logic cmp_en_x_pos,
	output logic cmp_en_y_pos,
	output logic cmp_en_x_neg,
	output logic cmp_en_y_neg,
	output logic arm_pin_en_x,
	output logic arm_pin_en_y,
	output logic init_in_progress,
	output logic irq
);

	acfg_pkg::acfg_state_t st_reg;
	acfg_pkg::acfg_state_t st_next;

	// Serial CRC over the writable data, MSB first
	function automatic logic [2:0] crc3(input logic [39:0] d);
		logic [2:0] c;
		logic fb;
		c = `ACFG_CRC_SEED;
		for (int i = 39; i >= 0; i--)
		begin
			fb = d[i] ^ c[2];
			c = {c[1], c[0] ^ fb, fb};
		end
		return c;
	endfunction

	// Average window length: 2 shifted by the code
	function automatic logic [4:0] avg_len(input logic [1:0] code);
		return 5'(5'h02 << code);
	endfunction

	// Count limit: one less than the average length
	function automatic logic [3:0] cnt_lim(input logic [1:0] code);
		return 4'(avg_len(code) - 5'h01);
	endfunction

	logic [39:0] crc_data;
	logic [2:0] crc_now;
	logic sclk_rise;
	logic wr_fire;
	logic rd_fire;
	logic [5:0] ar_idx;
	logic [4:0] evt_now;
	logic init_busy;
	logic init_end;
	logic [7:0] flags_view;

	// Thresholds and window fields together form the protected set
	assign crc_data = {st_reg.win_cfg, st_reg.thr};
	assign crc_now = crc3(crc_data);
	assign sclk_rise = st_reg.sclk_s2 & ~st_reg.sclk_d;
	assign wr_fire = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
	assign rd_fire = arvalid & st_reg.arready;
	assign ar_idx = araddr[7:2];
	assign init_busy = st_reg.flags[`ACFG_FLAG_INIT];
	assign init_end = init_busy && (st_reg.init_cnt >= 16'(INIT_CYCLES - 1));
	assign flags_view = st_reg.flags;

	// Edge events only count on a sample edge so a single fault
	// is not seen twice when the link clock is slow
	always_comb
	begin
		evt_now = '0;
		evt_now[`ACFG_IRQ_OFFX] = st_reg.evt_s2[0] & sclk_rise;
		evt_now[`ACFG_IRQ_OFFY] = st_reg.evt_s2[1] & sclk_rise;
		evt_now[`ACFG_IRQ_MISO] = st_reg.evt_s2[2] & sclk_rise;
		evt_now[`ACFG_IRQ_DFAULT] = st_reg.evt_s2[3] | st_reg.evt_s2[4]
			| st_reg.crc_fault;
		evt_now[`ACFG_IRQ_INIT] = init_end;
	end

	// Next-state logic for the whole block
	always_comb
	begin
		st_next = st_reg;

		// Two-flop synchronisers for link clock and fault pins
		st_next.sclk_s1 = link_sample_clk;
		st_next.sclk_s2 = st_reg.sclk_s1;
		st_next.sclk_d = st_reg.sclk_s2;
		st_next.evt_s1 = {internal_fault, fuse_data_fault, miso_mismatch,
			offset_y_hit, offset_x_hit};
		st_next.evt_s2 = st_reg.evt_s1;

		// Write address and data channels taken independently
		if (awvalid && st_reg.awready)
		begin
			st_next.aw_held = 1'b1;
			st_next.aw_idx = awaddr[7:2];
			st_next.awready = 1'b0;
		end
		if (wvalid && st_reg.wready)
		begin
			st_next.w_held = 1'b1;
			st_next.wdata = wdata[7:0];
			st_next.wstrb0 = wstrb[0];
			st_next.wready = 1'b0;
		end

		// Register write once both halves are held
		if (wr_fire)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `ACFG_RESP_OKAY;
			case (st_reg.aw_idx)
				`ACFG_IDX_THR_XP, `ACFG_IDX_THR_YP,
				`ACFG_IDX_THR_XN, `ACFG_IDX_THR_YN:
				begin
					// Locked writes answer OKAY but change nothing
					if (st_reg.wstrb0 && !st_reg.lock)
						st_next.thr[st_reg.aw_idx[1:0]] = st_reg.wdata;
				end
				`ACFG_IDX_WIN_CFG:
				begin
					if (st_reg.wstrb0 && !st_reg.lock)
						st_next.win_cfg = st_reg.wdata;
				end
				`ACFG_IDX_SETUP:
				begin
					if (st_reg.wstrb0 && !st_reg.lock)
					begin
						st_next.mode = acfg_pkg::acfg_mode_t'(
							st_reg.wdata[`ACFG_SETUP_MODE_LSB +: 2]);
						// Once set the lock only falls with reset
						st_next.lock = st_reg.wdata[`ACFG_SETUP_LOCK_BIT];
						st_next.crc_ref = crc_now;
					end
				end
				`ACFG_IDX_IRQ_MASK:
				begin
					if (st_reg.wstrb0)
						st_next.irq_mask = st_reg.wdata[4:0];
				end
				`ACFG_IDX_IRQ_STAT:
				begin
					if (st_reg.wstrb0)
						st_next.irq_stat = st_reg.irq_stat & ~st_reg.wdata[4:0];
				end
				`ACFG_IDX_DEV_FLAGS:
				begin
					// Read-only register, write has no effect
					st_next.bresp = `ACFG_RESP_OKAY;
				end
				default:
				begin
					st_next.bresp = `ACFG_RESP_SLVERR;
				end
			endcase
		end

		// Response handshake frees the write channels again
		if (st_reg.bvalid && bready)
		begin
			st_next.bvalid = 1'b0;
			st_next.awready = 1'b1;
			st_next.wready = 1'b1;
		end

		// Read channel: take address, answer next cycle
		if (rd_fire)
		begin
			st_next.arready = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rresp = `ACFG_RESP_OKAY;
			st_next.rdata = 8'h00;
			case (ar_idx)
				`ACFG_IDX_THR_XP, `ACFG_IDX_THR_YP,
				`ACFG_IDX_THR_XN, `ACFG_IDX_THR_YN:
					st_next.rdata = st_reg.thr[ar_idx[1:0]];
				`ACFG_IDX_WIN_CFG:
					st_next.rdata = st_reg.win_cfg;
				`ACFG_IDX_DEV_FLAGS:
				begin
					st_next.rdata = flags_view;
					// Transient flags drop; init flag is untouched
					st_next.flags[`ACFG_FLAG_DFAULT] = 1'b0;
					st_next.flags[`ACFG_FLAG_MISO] = 1'b0;
					st_next.flags[`ACFG_FLAG_OFFY] = 1'b0;
					st_next.flags[`ACFG_FLAG_OFFX] = 1'b0;
					st_next.flags[`ACFG_FLAG_RST] = 1'b0;
				end
				`ACFG_IDX_SETUP:
				begin
					st_next.rdata[`ACFG_SETUP_LOCK_BIT] = st_reg.lock;
					st_next.rdata[`ACFG_SETUP_MODE_LSB +: 2] = st_reg.mode;
					st_next.rdata[`ACFG_SETUP_CRCF_BIT] = st_reg.crc_fault;
				end
				`ACFG_IDX_IRQ_STAT:
					st_next.rdata = {3'h0, st_reg.irq_stat};
				`ACFG_IDX_IRQ_MASK:
					st_next.rdata = {3'h0, st_reg.irq_mask};
				default:
					st_next.rresp = `ACFG_RESP_SLVERR;
			endcase
		end
		if (st_reg.rvalid && rready)
		begin
			st_next.rvalid = 1'b0;
			st_next.arready = 1'b1;
		end

		// Initialization timer; the flag clears itself at the end
		if (init_busy)
			st_next.init_cnt = st_reg.init_cnt + 16'h0001;
		if (init_end)
			st_next.flags[`ACFG_FLAG_INIT] = 1'b0;

		// CRC compare only while locked; fault sticks until reset
		if (st_reg.lock && (crc_now != st_reg.crc_ref))
			st_next.crc_fault = 1'b1;

		// Flag sets come last so they win over a clearing read
		if (evt_now[`ACFG_IRQ_DFAULT])
			st_next.flags[`ACFG_FLAG_DFAULT] = 1'b1;
		if (evt_now[`ACFG_IRQ_MISO])
			st_next.flags[`ACFG_FLAG_MISO] = 1'b1;
		if (evt_now[`ACFG_IRQ_OFFY])
			st_next.flags[`ACFG_FLAG_OFFY] = 1'b1;
		if (evt_now[`ACFG_IRQ_OFFX])
			st_next.flags[`ACFG_FLAG_OFFX] = 1'b1;
		if (init_busy)
			st_next.flags[`ACFG_FLAG_RST] = 1'b1;
		// Unused bits never carry a value
		st_next.flags[7] = 1'b0;
		st_next.flags[5] = 1'b0;

		// Sticky interrupt status, set wins over write-one-clear
		st_next.irq_stat = st_next.irq_stat | evt_now;
		st_next.irq = |(st_reg.irq_stat & st_reg.irq_mask);

		// Decoded window sizes, one per axis and polarity
		st_next.win_len[0] = avg_len(st_reg.win_cfg[`ACFG_WIN_XP_LSB +: 2]);
		st_next.win_len[1] = avg_len(st_reg.win_cfg[`ACFG_WIN_XN_LSB +: 2]);
		st_next.win_len[2] = avg_len(st_reg.win_cfg[`ACFG_WIN_YP_LSB +: 2]);
		st_next.win_len[3] = avg_len(st_reg.win_cfg[`ACFG_WIN_YN_LSB +: 2]);

		// Count limit ignores the negative fields entirely
		st_next.lim_x = cnt_lim(st_reg.win_cfg[`ACFG_WIN_XP_LSB +: 2]);
		st_next.lim_y = cnt_lim(st_reg.win_cfg[`ACFG_WIN_YP_LSB +: 2]);

		// A zero threshold disables just its own polarity
		for (int i = 0; i < 4; i++)
			st_next.cmp_en[i] = (st_reg.thr[i] != `ACFG_THR_RST);

		// Axis and pin die only if both polarities are zero
		st_next.pin_en_x = (st_reg.thr[0] != `ACFG_THR_RST)
			|| (st_reg.thr[2] != `ACFG_THR_RST);
		st_next.pin_en_y = (st_reg.thr[1] != `ACFG_THR_RST)
			|| (st_reg.thr[3] != `ACFG_THR_RST);

		// Synchronous reset; init and reset flags start set
		if (!aresetn)
		begin
			st_next = '0;
			st_next.awready = 1'b1;
			st_next.wready = 1'b1;
			st_next.arready = 1'b1;
			st_next.win_cfg = `ACFG_WIN_RST;
			st_next.crc_ref = `ACFG_CRC_SEED;
			st_next.flags[`ACFG_FLAG_INIT] = 1'b1;
			// Decoded outputs follow the reset window code at once,
			// so no illegal zero length is shown after release
			for (int i = 0; i < 4; i++)
				st_next.win_len[i] = `ACFG_WIN_LEN_RST;
			st_next.lim_x = `ACFG_CNT_LIM_RST;
			st_next.lim_y = `ACFG_CNT_LIM_RST;
			st_next.flags[`ACFG_FLAG_RST] = 1'b1;
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		st_reg <= st_next;
	end

	// Outputs taken straight from the state register
	assign awready = st_reg.awready;
	assign wready = st_reg.wready;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = st_reg.arready;
	assign rvalid = st_reg.rvalid;
	assign rresp = st_reg.rresp;
	assign rdata = {24'h000000, st_reg.rdata};
	assign arm_mode = st_reg.mode;
	assign thresh_value_x_pos = st_reg.thr[0];
	assign thresh_value_y_pos = st_reg.thr[1];
	assign thresh_value_x_neg = st_reg.thr[2];
	assign thresh_value_y_neg = st_reg.thr[3];
	assign window_len_x_pos = st_reg.win_len[0];
	assign window_len_x_neg = st_reg.win_len[1];
	assign window_len_y_pos = st_reg.win_len[2];
	assign window_len_y_neg = st_reg.win_len[3];
	assign count_limit_x = st_reg.lim_x;
	assign count_limit_y = st_reg.lim_y;
	assign cmp_en_x_pos = st_reg.cmp_en[0];
	assign cmp_en_y_pos = st_reg.cmp_en[1];
	assign cmp_en_x_neg = st_reg.cmp_en[2];
	assign cmp_en_y_neg = st_reg.cmp_en[3];
	assign arm_pin_en_x = st_reg.pin_en_x;
	assign arm_pin_en_y = st_reg.pin_en_y;
	assign init_in_progress = st_reg.flags[`ACFG_FLAG_INIT];
	assign irq = st_reg.irq;

endmodule

// ---- rtl/acfg_regs.svh ----
// Register indices, field positions, reset values and timing counts
// for the arming configuration and status register bank.
// Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
`ifndef ACFG_REGS_SVH
`define ACFG_REGS_SVH

// Register indices; byte address is four times the index
`define ACFG_IDX_WIN_CFG 6'h0e
`define ACFG_IDX_THR_XP 6'h10
`define ACFG_IDX_THR_YP 6'h11
`define ACFG_IDX_THR_XN 6'h12
`define ACFG_IDX_THR_YN 6'h13
`define ACFG_IDX_DEV_FLAGS 6'h14
`define ACFG_IDX_SETUP 6'h18
`define ACFG_IDX_IRQ_STAT 6'h19
`define ACFG_IDX_IRQ_MASK 6'h1a

// Window config field positions (2 bits each)
`define ACFG_WIN_XP_LSB 0
`define ACFG_WIN_XN_LSB 2
`define ACFG_WIN_YP_LSB 4
`define ACFG_WIN_YN_LSB 6
`define ACFG_WIN_RST 8'hff
`define ACFG_THR_RST 8'h00
`define ACFG_WIN_LEN_RST 5'h10
`define ACFG_CNT_LIM_RST 4'hf

// Setup register fields
`define ACFG_SETUP_LOCK_BIT 0
`define ACFG_SETUP_MODE_LSB 1
`define ACFG_SETUP_CRCF_BIT 3

// Device condition flag positions
`define ACFG_FLAG_DFAULT 6
`define ACFG_FLAG_INIT 4
`define ACFG_FLAG_MISO 3
`define ACFG_FLAG_OFFY 2
`define ACFG_FLAG_OFFX 1
`define ACFG_FLAG_RST 0

// Interrupt status / mask positions
`define ACFG_IRQ_DFAULT 0
`define ACFG_IRQ_MISO 1
`define ACFG_IRQ_OFFX 2
`define ACFG_IRQ_OFFY 3
`define ACFG_IRQ_INIT 4

// CRC seed
`define ACFG_CRC_SEED 3'h7

// Timing
`define ACFG_CLK_PERIOD_NS 5
`define ACFG_INIT_TIME_NS 50000
`define ACFG_INIT_CYCLES (`ACFG_INIT_TIME_NS / `ACFG_CLK_PERIOD_NS)

// AXI responses
`define ACFG_RESP_OKAY 2'h0
`define ACFG_RESP_SLVERR 2'h2

`endif

// ---- rtl/acfg_pkg.sv ----
// Types shared by the arming configuration register bank.
// Assumes acfg_regs.svh carries all numeric constants.
package acfg_pkg;

	// Arming mode selection
	typedef enum logic [1:0] {
		ACFG_ARM_OFF = 2'b00,
		ACFG_ARM_AVG = 2'b01,
		ACFG_ARM_CNT = 2'b10,
		ACFG_ARM_RSV = 2'b11
	} acfg_mode_t;

	// Whole state of the block
	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_d;
		logic [4:0] evt_s1;
		logic [4:0] evt_s2;
		logic aw_held;
		logic [5:0] aw_idx;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [3:0][7:0] thr;
		logic [7:0] win_cfg;
		logic lock;
		acfg_mode_t mode;
		logic [2:0] crc_ref;
		logic crc_fault;
		logic [15:0] init_cnt;
		logic [7:0] flags;
		logic [4:0] irq_stat;
		logic [4:0] irq_mask;
		logic irq;
		logic [3:0][4:0] win_len;
		logic [3:0] lim_x;
		logic [3:0] lim_y;
		logic [3:0] cmp_en;
		logic pin_en_x;
		logic pin_en_y;
	} acfg_state_t;

endpackage

// ---- test/acfg_top_monitor.sv ----
// Checker for the arming register bank, bound to acfg_top.
// Assumes it sees only the top ports; aclk and aresetn form one domain.
`timescale 1ns/1ps
`include "acfg_regs.svh"
module acfg_top_monitor #(
	parameter int INIT_CYCLES = `ACFG_INIT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic [4:0] window_len_x_pos,
	input wire logic [4:0] window_len_x_neg,
	input wire logic [3:0] count_limit_x,
	input wire logic [7:0] thresh_value_x_pos,
	input wire logic [7:0] thresh_value_x_neg,
	input wire logic cmp_en_x_pos,
	input wire logic arm_pin_en_x,
	input wire logic init_in_progress
);
	// One domain, so clock and disable are stated once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Handshake steps of the register bus
	sequence rd_take;
		arvalid && arready;
	endsequence
	sequence wr_take;
		awvalid && awready && wvalid && wready;
	endsequence

	// Cycles since reset release, saturating; init length is exact
	int unsigned init_age;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			init_age <= 0;
		else if (init_age < INIT_CYCLES + 4)
			init_age <= init_age + 1;
	end

	win_code_a: assert property ($onehot(window_len_x_pos[4:1])
		&& !window_len_x_pos[0] && $onehot(window_len_x_neg[4:1]))
		else $error("window length not 2, 4, 8 or 16");
	cnt_limit_a: assert property (
		count_limit_x == window_len_x_pos - 5'h01)
		else $error("count limit not tied to positive window");
	thr_cmp_a: assert property (
		cmp_en_x_pos == ($past(thresh_value_x_pos) != 8'h00))
		else $error("compare enable does not follow threshold");
	axis_off_a: assert property (
		arm_pin_en_x == (|$past(thresh_value_x_pos)
		|| |$past(thresh_value_x_neg)))
		else $error("axis pin enable wrong");
	init_hold_a: assert property ($rose(aresetn) |-> init_in_progress [*8])
		else $error("init flag dropped early");
	init_len_a: assert property (
		init_in_progress == (init_age < INIT_CYCLES))
		else $error("init flag length wrong");
	init_stay_a: assert property (
		!init_in_progress |=> !init_in_progress)
		else $error("init flag came back without reset");
	rd_high_a: assert property (
		rvalid |-> rdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	rd_lat_a: assert property (rd_take |=> rvalid)
		else $error("read answer late");
	wr_lat_a: assert property (wr_take |-> ##[1:2] bvalid)
		else $error("write answer late");
	rd_stand_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer not held");
endmodule

bind acfg_top acfg_top_monitor #(.INIT_CYCLES(INIT_CYCLES)) i_mon (.*);

// ---- test/acfg_link_partner.sv ----
// Model of the sensing side: link sample clock and event levels.
// Assumes the bench enables it only while events are being sent.
`timescale 1ns/1ps
module acfg_link_partner (
	input wire logic link_en,
	input wire logic [2:0] evt_req,
	output logic link_sample_clk,
	output logic offset_x_hit,
	output logic offset_y_hit,
	output logic miso_mismatch
);
	initial
	begin
		link_sample_clk = 1'b0;
		{miso_mismatch, offset_y_hit, offset_x_hit} = 3'h0;
	end
	// Clock stands still outside bursts, as the real source would
	always #40 if (link_en) link_sample_clk = ~link_sample_clk;
	// Launch on the falling edge so levels are steady at the rising one
	always @(negedge link_sample_clk)
		{miso_mismatch, offset_y_hit, offset_x_hit} <= evt_req;
endmodule

// ---- test/tb_arming_config_and_status_regs.sv ----
// Self-checking bench for acfg_top over AXI4-Lite.
// Assumes the partner model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_arming_config_and_status_regs;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic fuse_data_fault, internal_fault, link_en;
	logic [2:0] evt_req;
	logic awready, wready, bvalid, arready, rvalid, irq, init_in_progress;
	logic [1:0] bresp, rresp, arm_mode, rr;
	logic [31:0] rdata, rv;
	logic [7:0] thresh_value_x_pos, thresh_value_y_pos;
	logic [7:0] thresh_value_x_neg, thresh_value_y_neg;
	logic [4:0] window_len_x_pos, window_len_x_neg;
	logic [4:0] window_len_y_pos, window_len_y_neg;
	logic [3:0] count_limit_x, count_limit_y;
	logic cmp_en_x_pos, cmp_en_y_pos, cmp_en_x_neg, cmp_en_y_neg;
	logic arm_pin_en_x, arm_pin_en_y;
	logic link_sample_clk, offset_x_hit, offset_y_hit, miso_mismatch;
	int errors = 0;
	int cmp_count = 0;

	// Short init count keeps the run brief
	acfg_top #(.INIT_CYCLES(20)) i_dut (.*);
	acfg_link_partner i_link (.*);

	always #2.5 aclk = ~aclk;

	task automatic summarize();
		$display("Counts: %0d compares, %0d errors", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// A spent bound counts as a mismatch and ends the run
	task automatic tmo(input int n);
		if (n >= 60)
		begin
			errors++;
			$display("ERROR t=%0t timeout got %h exp %h", $time, n, 0);
			summarize();
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		tmo(n);
		rr = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		tmo(n);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	task automatic do_reset();
		int n;
		aresetn <= 1'b0;
		cyc(20);
		aresetn <= 1'b1;
		rd(8'h50);
		chk(rv, 32'h11);
		for (n = 0; n < 60 && init_in_progress !== 1'b0; n++) @(posedge aclk);
		tmo(n);
	endtask

	task automatic t_reset();
		rd(8'h50);
		chk(rv, 32'h01);
		rd(8'h50);
		chk(rv, 32'h00);
		rd(8'h38);
		chk(rv, 32'hff);
		$display("reset test done");
	endtask

	task automatic t_bus();
		rd(8'h7c);
		chk({rr, rv[29:0]}, 32'h80000000);
		wr(8'h7c, 8'h00);
		chk(rr, 32'h2);
		wr(8'h50, 8'hff);
		rd(8'h50);
		chk(rv, 32'h00);
		// A write without the low byte lane stores nothing
		wstrb <= 4'h0;
		wr(8'h40, 8'h33);
		wstrb <= 4'hf;
		rd(8'h40);
		chk(rv, 32'h00);
		$display("bus test done");
	endtask

	// Every mode code, then every window code with neg fields differing
	task automatic t_window();
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h60, 8'(m << 1));
			cyc(2);
			chk(arm_mode, m);
		end
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h38, {2'(3 - c), 2'(c), 2'(3 - c), 2'(c)});
			cyc(2);
			chk(window_len_x_pos, 32'h2 << c);
			chk(window_len_x_neg, 32'h2 << (3 - c));
			chk(window_len_y_pos, 32'h2 << c);
			chk(window_len_y_neg, 32'h2 << (3 - c));
			chk(count_limit_x, (32'h2 << c) - 1);
			chk(count_limit_y, (32'h2 << c) - 1);
		end
		$display("window test done");
	endtask

	task automatic t_thresh();
		wr(8'h40, 8'h64);
		chk(rr, 32'h0);
		wr(8'h44, 8'h00);
		wr(8'h48, 8'h00);
		wr(8'h4c, 8'h01);
		cyc(2);
		chk(thresh_value_x_pos, 32'h64);
		chk({thresh_value_y_pos, thresh_value_x_neg}, 32'h0);
		chk(thresh_value_y_neg, 32'h1);
		chk({cmp_en_x_pos, cmp_en_x_neg, cmp_en_y_neg}, 32'h5);
		chk(cmp_en_y_pos, 32'h0);
		chk({arm_pin_en_x, arm_pin_en_y}, 32'h3);
		wr(8'h4c, 8'h00);
		cyc(2);
		chk({arm_pin_en_x, arm_pin_en_y}, 32'h2);
		rd(8'h40);
		chk(rv, 32'h64);
		chk(rr, 32'h0);
		$display("threshold test done");
	endtask

	task automatic t_lock();
		wr(8'h60, 8'h05);
		cyc(2);
		chk(arm_mode, 32'h2);
		wr(8'h40, 8'h55);
		chk(rr, 32'h0);
		rd(8'h40);
		chk(rv, 32'h64);
		wr(8'h38, 8'h00);
		cyc(2);
		chk(window_len_x_pos, 32'h10);
		wr(8'h60, 8'h00);
		rd(8'h60);
		chk(rv, 32'h05);
		$display("lock test done");
	endtask

	// Offset x, offset y, then output mismatch across the link clock
	task automatic t_flags();
		link_en <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			evt_req <= 3'(1 << i);
			cyc(20);
			evt_req <= 3'h0;
			cyc(80);
			rd(8'h50);
			chk(rv, 32'h2 << i);
			rd(8'h50);
			chk(rv, 32'h0);
		end
		link_en <= 1'b0;
		$display("flag test done");
	endtask

	task automatic t_irq();
		rd(8'h64);
		chk(rv, 32'h1e);
		chk(irq, 32'h0);
		wr(8'h68, 8'h04);
		cyc(3);
		chk(irq, 32'h1);
		wr(8'h64, 8'h04);
		cyc(3);
		chk(irq, 32'h0);
		rd(8'h64);
		chk(rv, 32'h1a);
		$display("interrupt test done");
	endtask

	// Fuse fault is left high across a second reset
	task automatic t_fault();
		internal_fault <= 1'b1;
		cyc(5);
		internal_fault <= 1'b0;
		cyc(5);
		rd(8'h50);
		chk(rv, 32'h40);
		rd(8'h50);
		chk(rv, 32'h00);
		fuse_data_fault <= 1'b1;
		cyc(5);
		rd(8'h50);
		rd(8'h50);
		chk(rv, 32'h40);
		do_reset();
		rd(8'h50);
		chk(rv, 32'h41);
		rd(8'h60);
		chk(rv, 32'h00);
		$display("fault test done");
	endtask

	initial
	begin
		aclk = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		{fuse_data_fault, internal_fault, link_en} = 3'h0;
		evt_req = 3'h0;
		do_reset();
		t_reset();
		t_bus();
		t_window();
		t_thresh();
		t_lock();
		t_flags();
		t_irq();
		t_fault();
		summarize();
	end
endmodule
